// [pkg/mac_rx_err_pkg.sv]
// constants, field layouts and states for the mac receive error checker
// assumes one system clock domain; the mii receive clock is only sampled
package mac_rx_err_pkg;
  localparam logic [15:0] MAX_FRAME_LEN = 16'h05EE;
  localparam logic [3:0]  PREAMBLE_NIB  = 4'h5;
  localparam logic [3:0]  SFD_NIB       = 4'hD;
  localparam logic [31:0] CRC_INIT      = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY      = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE   = 32'hDEBB20E3;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0C;
  localparam logic [1:0]  CTRL_RST      = 2'h0;
  localparam logic [5:0]  IRQ_MASK_RST  = 6'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam int          CTRL_LONG_BIT = 0;
  localparam int          CTRL_PINJ_BIT = 1;

  typedef struct packed {
    logic parity;
    logic overrun;
    logic too_long;
    logic crc;
    logic align;
  } rx_err_t;

  typedef struct packed {
    rx_err_t     err;
    logic [15:0] length;
  } rx_status_t;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_PREAMBLE = 2'b01,
    ST_DATA     = 2'b10,
    ST_DROP     = 2'b11
  } rx_state_t;
endpackage : mac_rx_err_pkg

// [hw/mac_rx_err_check.sv]
// mii receive path with receive fifo, frame error checks and axi4-lite registers
// assumes rx clock, dv, er and data arrive unsynchronised from the phy
//
// The AXI4-Lite slave port and the address map were decided locally.

module mac_rx_err_check #(
  parameter int DEPTH = 16
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RESET_N,
  input  wire logic        I_RX_CLK,
  input  wire logic        I_RX_DV,
  input  wire logic        I_RX_ER,
  input  wire logic [3:0]  I_RXD,
  output logic      [7:0]  O_RX_BYTE,
  output logic             O_RX_VALID,
  input  wire logic        I_RX_READY,
  output logic      [20:0] O_STATUS_WORD,
  output logic             O_STATUS_VALID,
  output logic             O_IRQ,
  input  wire logic [7:0]  I_AXI_AWADDR,
  input  wire logic        I_AXI_AWVALID,
  output logic             O_AXI_AWREADY,
  input  wire logic [31:0] I_AXI_WDATA,
  input  wire logic [3:0]  I_AXI_WSTRB,
  input  wire logic        I_AXI_WVALID,
  output logic             O_AXI_WREADY,
  output logic      [1:0]  O_AXI_BRESP,
  output logic             O_AXI_BVALID,
  input  wire logic        I_AXI_BREADY,
  input  wire logic [7:0]  I_AXI_ARADDR,
  input  wire logic        I_AXI_ARVALID,
  output logic             O_AXI_ARREADY,
  output logic      [31:0] O_AXI_RDATA,
  output logic      [1:0]  O_AXI_RRESP,
  output logic             O_AXI_RVALID,
  input  wire logic        I_AXI_RREADY
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ mac_rx_err_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // two-stage synchroniser; stage one feeds stage two only
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic       clk_prev_q;
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sync1_q    <= 7'h00;
      sync2_q    <= 7'h00;
      clk_prev_q <= 1'b0;
    end else begin
      sync1_q    <= {I_RX_CLK, I_RX_DV, I_RX_ER, I_RXD};
      sync2_q    <= sync1_q;
      clk_prev_q <= sync2_q[6];
    end
  end
  logic       rx_rise;
  logic       dv;
  logic       er;
  logic [3:0] nib;
  assign rx_rise = sync2_q[6] & ~clk_prev_q;
  assign dv      = sync2_q[5];
  assign er      = sync2_q[4];
  assign nib     = sync2_q[3:0];

  // registers
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic [5:0] irq_stat_q;
  logic [5:0] irq_stat_d;
  logic [5:0] irq_mask_q;
  logic [5:0] irq_mask_d;

  // fifo
  logic [8:0]    mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] wr_ptr_d;
  logic [PW-1:0] rd_ptr_q;
  logic [PW-1:0] rd_ptr_d;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic          push;
  logic          pop;
  logic          full;
  logic [7:0]    push_byte;
  logic          par_bad;

  assign full       = (count_q == CW'(DEPTH));
  assign O_RX_VALID = (count_q != '0);
  assign O_RX_BYTE  = mem_q[rd_ptr_q][7:0];
  assign pop        = O_RX_VALID & I_RX_READY;
  assign par_bad    = pop & (^mem_q[rd_ptr_q] != 1'b0);

  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    if (push && !full) begin
      wr_ptr_d = (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    end
    if (pop) begin
      rd_ptr_d = (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
    end
    count_d = count_q + CW'(push && !full) - CW'(pop);
  end
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
    end
  end
  // storage has no reset; count guards every read
  always_ff @(posedge I_CLK) begin
    if (push && !full) begin
      // even parity stored; the inject bit flips it so the check can be exercised
      mem_q[wr_ptr_q] <= {(^push_byte) ^ ctrl_q[mac_rx_err_pkg::CTRL_PINJ_BIT], push_byte};
    end
  end

  // receive state machine
  mac_rx_err_pkg::rx_state_t  state_q;
  mac_rx_err_pkg::rx_state_t  state_d;
  mac_rx_err_pkg::rx_err_t    err_q;
  mac_rx_err_pkg::rx_err_t    err_d;
  mac_rx_err_pkg::rx_status_t stat_q;
  mac_rx_err_pkg::rx_status_t stat_d;
  logic [31:0] crc_q;
  logic [31:0] crc_d;
  logic [15:0] len_q;
  logic [15:0] len_d;
  logic [3:0]  low_q;
  logic [3:0]  low_d;
  logic        half_q;
  logic        half_d;
  logic        done_q;
  logic        done_d;
  logic        crc_bad;

  assign crc_bad = (crc_q != mac_rx_err_pkg::CRC_RESIDUE);

  always_comb begin
    state_d   = state_q;
    err_d     = err_q;
    stat_d    = stat_q;
    crc_d     = crc_q;
    len_d     = len_q;
    low_d     = low_q;
    half_d    = half_q;
    done_d    = 1'b0;
    push      = 1'b0;
    push_byte = {nib, low_q};
    if (rx_rise) begin
      case (state_q)
        mac_rx_err_pkg::ST_IDLE: begin
          if (dv) begin
            state_d = (nib == mac_rx_err_pkg::PREAMBLE_NIB) ?
                      mac_rx_err_pkg::ST_PREAMBLE : mac_rx_err_pkg::ST_DROP;
          end
        end
        mac_rx_err_pkg::ST_PREAMBLE: begin
          if (!dv) begin
            state_d = mac_rx_err_pkg::ST_IDLE;
          end else if (nib == mac_rx_err_pkg::SFD_NIB) begin
            state_d = mac_rx_err_pkg::ST_DATA;
            err_d   = '0;
            crc_d   = mac_rx_err_pkg::CRC_INIT;
            len_d   = 16'h0000;
            half_d  = 1'b0;
          end else if (nib != mac_rx_err_pkg::PREAMBLE_NIB) begin
            state_d = mac_rx_err_pkg::ST_DROP;
          end
        end
        mac_rx_err_pkg::ST_DATA: begin
          if (dv) begin
            if (er) begin
              err_d.crc = 1'b1;
            end
            half_d = ~half_q;
            if (!half_q) begin
              low_d = nib;
            end else begin
              push  = 1'b1;
              crc_d = crc_byte(crc_q, {nib, low_q});
              len_d = (len_q == 16'hFFFF) ? len_q : len_q + 16'h0001;
              if (full) begin
                err_d.overrun = 1'b1;
              end
            end
          end else begin
            // frame end: final checks on the completed frame
            err_d.crc      = err_q.crc | crc_bad;
            err_d.align    = half_q & crc_bad;
            err_d.too_long = (len_q > mac_rx_err_pkg::MAX_FRAME_LEN) &
                             ~ctrl_q[mac_rx_err_pkg::CTRL_LONG_BIT];
            state_d        = mac_rx_err_pkg::ST_IDLE;
            done_d         = 1'b1;
          end
        end
        mac_rx_err_pkg::ST_DROP: begin
          if (!dv) begin
            state_d = mac_rx_err_pkg::ST_IDLE;
          end
        end
        default: state_d = mac_rx_err_pkg::ST_IDLE;
      endcase
    end
    if (par_bad) begin
      err_d.parity = 1'b1;
    end
    if (done_q) begin
      stat_d = '{err: err_q, length: len_q};
    end
  end
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q <= mac_rx_err_pkg::ST_IDLE;
      err_q   <= '0;
      stat_q  <= '0;
      crc_q   <= mac_rx_err_pkg::CRC_INIT;
      len_q   <= 16'h0000;
      low_q   <= 4'h0;
      half_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      err_q   <= err_d;
      stat_q  <= stat_d;
      crc_q   <= crc_d;
      len_q   <= len_d;
      low_q   <= low_d;
      half_q  <= half_d;
      done_q  <= done_d;
    end
  end

  // status word goes out one cycle after the flags settle
  logic status_valid_q;
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      status_valid_q <= 1'b0;
    end else begin
      status_valid_q <= done_q;
    end
  end
  assign O_STATUS_WORD  = stat_q;
  assign O_STATUS_VALID = status_valid_q;

  // axi4-lite slave; write taken when address and data are both offered
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        wr_go;
  logic        rd_go;
  logic [5:0]  w1c;
  logic [5:0]  events;

  assign wr_go         = I_AXI_AWVALID & I_AXI_WVALID & ~bvalid_q;
  assign rd_go         = I_AXI_ARVALID & ~rvalid_q;
  assign O_AXI_AWREADY = wr_go;
  assign O_AXI_WREADY  = wr_go;
  assign O_AXI_ARREADY = rd_go;
  assign O_AXI_BVALID  = bvalid_q;
  assign O_AXI_BRESP   = bresp_q;
  assign O_AXI_RVALID  = rvalid_q;
  assign O_AXI_RRESP   = rresp_q;
  assign O_AXI_RDATA   = rdata_q;
  assign events        = {done_q, err_q & {5{done_q}}};
  assign O_IRQ         = |(irq_stat_q & irq_mask_q);

  always_comb begin
    bvalid_d   = bvalid_q & ~I_AXI_BREADY;
    bresp_d    = bresp_q;
    rvalid_d   = rvalid_q & ~I_AXI_RREADY;
    rresp_d    = rresp_q;
    rdata_d    = rdata_q;
    ctrl_d     = ctrl_q;
    irq_mask_d = irq_mask_q;
    w1c        = 6'h00;
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d  = mac_rx_err_pkg::RESP_OKAY;
      case (I_AXI_AWADDR)
        mac_rx_err_pkg::ADDR_CTRL: begin
          if (I_AXI_WSTRB[0]) ctrl_d = I_AXI_WDATA[1:0];
        end
        mac_rx_err_pkg::ADDR_STATUS: ;
        mac_rx_err_pkg::ADDR_IRQ_STAT: begin
          if (I_AXI_WSTRB[0]) w1c = I_AXI_WDATA[5:0];
        end
        mac_rx_err_pkg::ADDR_IRQ_MASK: begin
          if (I_AXI_WSTRB[0]) irq_mask_d = I_AXI_WDATA[5:0];
        end
        default: bresp_d = mac_rx_err_pkg::RESP_SLVERR;
      endcase
    end
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d  = mac_rx_err_pkg::RESP_OKAY;
      case (I_AXI_ARADDR)
        mac_rx_err_pkg::ADDR_CTRL:     rdata_d = {30'h0, ctrl_q};
        mac_rx_err_pkg::ADDR_STATUS:   rdata_d = {11'h0, stat_q};
        mac_rx_err_pkg::ADDR_IRQ_STAT: rdata_d = {26'h0, irq_stat_q};
        mac_rx_err_pkg::ADDR_IRQ_MASK: rdata_d = {26'h0, irq_mask_q};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = mac_rx_err_pkg::RESP_SLVERR;
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    irq_stat_d = (irq_stat_q & ~w1c) | events;
  end
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      bvalid_q   <= 1'b0;
      bresp_q    <= mac_rx_err_pkg::RESP_OKAY;
      rvalid_q   <= 1'b0;
      rresp_q    <= mac_rx_err_pkg::RESP_OKAY;
      rdata_q    <= 32'h00000000;
      ctrl_q     <= mac_rx_err_pkg::CTRL_RST;
      irq_stat_q <= 6'h00;
      irq_mask_q <= mac_rx_err_pkg::IRQ_MASK_RST;
    end else begin
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
      ctrl_q     <= ctrl_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  logic frame_end;
  assign frame_end = rx_rise & ~dv & (state_q == mac_rx_err_pkg::ST_DATA);

  chk_sfd_starts_data: assert property (
    rx_rise && dv && state_q == mac_rx_err_pkg::ST_PREAMBLE && nib == mac_rx_err_pkg::SFD_NIB
    |=> state_q == mac_rx_err_pkg::ST_DATA && len_q == 16'h0000)
    else $error("delimiter did not start data capture");
  chk_overrun_sets_flag: assert property (push && full |=> err_q.overrun)
    else $error("write into full fifo did not flag overrun");
  chk_parity_sets_flag: assert property (par_bad |=> err_q.parity)
    else $error("parity mismatch not flagged");
  chk_rx_er_crc_flag: assert property (
    rx_rise && dv && er && state_q == mac_rx_err_pkg::ST_DATA |=> err_q.crc)
    else $error("rx error did not set crc flag");
  chk_align_with_crc: assert property (
    status_valid_q |-> !(stat_q.err.align && !stat_q.err.crc))
    else $error("alignment error reported without crc error");
  chk_crc_bad_flag: assert property (frame_end && crc_bad |=> ##1 stat_q.err.crc)
    else $error("bad crc not reported");
  chk_long_frame_flag: assert property (
    frame_end && len_q > mac_rx_err_pkg::MAX_FRAME_LEN && !ctrl_q[mac_rx_err_pkg::CTRL_LONG_BIT]
    |=> ##1 stat_q.err.too_long)
    else $error("long frame not flagged");
  chk_status_handoff: assert property (
    frame_end |=> !status_valid_q ##1 status_valid_q ##1 !status_valid_q)
    else $error("status word not handed over once");
  chk_flags_clear_sfd: assert property (
    state_q == mac_rx_err_pkg::ST_PREAMBLE ##1 state_q == mac_rx_err_pkg::ST_DATA
    |-> !err_q.align && !err_q.too_long && !err_q.overrun)
    else $error("flags not cleared at frame start");

  cov_align_crc: cover property (status_valid_q && stat_q.err.align && stat_q.err.crc);
  cov_long_crc: cover property (status_valid_q && stat_q.err.too_long && stat_q.err.crc);
  cov_overrun: cover property (push && full);
  cov_irq_raised: cover property (!O_IRQ ##1 O_IRQ);
endmodule : mac_rx_err_check

// [verification/mii_phy_model.sv]
// mii phy model: preamble, delimiter, nibbles low first, then data valid drops
// assumes the receiver samples on the rising edge of o_rx_clk
module mii_phy_model (
  output logic       o_rx_clk,
  output logic       o_rx_dv,
  output logic       o_rx_er,
  output logic [3:0] o_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_rx_clk = 1'b0;
    o_rx_dv  = 1'b0;
    o_rx_er  = 1'b0;
    o_rxd    = 4'hA;
  end
  // 400 ns link period; the clock stands still between frames
  task automatic nib(input logic [3:0] n, input logic dv, input logic er);
    #200 o_rx_clk = 1'b0;
    o_rxd   = n;
    o_rx_dv = dv;
    o_rx_er = er;
    #200 o_rx_clk = 1'b1;
  endtask : nib
  task automatic send(input logic [7:0] b[$], input bit odd, input int er_at);
    // offset keeps link edges clear of the system clock edges
    #10;
    repeat (15) nib(4'h5, 1'b1, 1'b0);
    nib(4'hD, 1'b1, 1'b0);
    foreach (b[i]) begin
      nib(b[i][3:0], 1'b1, i == er_at);
      nib(b[i][7:4], 1'b1, 1'b0);
    end
    if (odd) nib(4'h3, 1'b1, 1'b0);
    // released data shows the inverse of the last nibble, never a stale copy
    nib(~o_rxd, 1'b0, 1'b0);
  endtask : send
endmodule : mii_phy_model

// [verification/mac_rx_err_check_tb.sv]
// self-checking bench: axi4-lite master, frames through the phy model, status checks
// assumes the phy model alone drives the mii pins
module mac_rx_err_check_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        I_CLK, I_RESET_N, rx_clk, rx_dv, rx_er, rdy, rxv, stv, irq;
  logic        awv, wv, bre, arv, rre, awr, wrr, bv, arr, rv;
  logic [3:0]  rxd;
  logic [7:0]  awa, ara, rxb;
  logic [31:0] wd, rdat, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic [20:0] stw;
  logic [7:0]  fr[$], got[$];
  int          n_fail, comparisons, cyc;

  mii_phy_model phy_i (.o_rx_clk(rx_clk), .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_rxd(rxd));
  mac_rx_err_check #(.DEPTH(4)) mac_rx_err_check_i (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_RX_CLK(rx_clk), .I_RX_DV(rx_dv),
    .I_RX_ER(rx_er), .I_RXD(rxd), .O_RX_BYTE(rxb), .O_RX_VALID(rxv), .I_RX_READY(rdy),
    .O_STATUS_WORD(stw), .O_STATUS_VALID(stv), .O_IRQ(irq), .I_AXI_AWADDR(awa),
    .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_WDATA(wd), .I_AXI_WSTRB(4'hF),
    .I_AXI_WVALID(wv), .O_AXI_WREADY(wrr), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bv),
    .I_AXI_BREADY(bre), .I_AXI_ARADDR(ara), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
    .O_AXI_RDATA(rdat), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rv), .I_AXI_RREADY(rre));

  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end
  // a pop seen at the falling edge lands at the next rising edge
  always @(negedge I_CLK) if (rxv === 1'b1 && rdy === 1'b1) got.push_back(rxb);
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 85000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // ready is judged at the falling edge; the item moves at the following rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic t;
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    t = 1'b0;
    while (t !== 1'b1) begin @(negedge I_CLK); t = awr & wrr; @(posedge I_CLK); end
    awv <= 1'b0;
    wv  <= 1'b0;
    t = 1'b0;
    while (t !== 1'b1) begin @(negedge I_CLK); t = bv; rsp = bresp; @(posedge I_CLK); end
    bre <= 1'b0;
    // one idle edge so a following call never re-raises bready in the same step
    @(posedge I_CLK);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    logic t;
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    t = 1'b0;
    while (t !== 1'b1) begin @(negedge I_CLK); t = arr; @(posedge I_CLK); end
    arv <= 1'b0;
    t = 1'b0;
    while (t !== 1'b1) begin @(negedge I_CLK); t = rv; rd = rdat; rsp = rresp; @(posedge I_CLK); end
    rre <= 1'b0;
    @(posedge I_CLK);
  endtask : rdr
  function automatic logic [31:0] crc(input logic [7:0] b[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (b[i]) begin
      c = c ^ {24'h0, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction : crc
  // e holds the expected flags {parity, overrun, too long, crc, align}
  task automatic frame(input int n, input bit bad, input bit odd, input int er, input logic [4:0] e);
    logic [31:0] f;
    int k;
    fr = {};
    got = {};
    for (int i = 0; i < n; i++) fr.push_back(8'(i * 13 + 1));
    f = crc(fr) ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) fr.push_back(f[8*i +: 8]);
    phy_i.send(fr, odd, er);
    k = 0;
    while (stv !== 1'b1 && k < 300) begin @(negedge I_CLK); k++; end
    chk("status pulse", {31'h0, stv}, 32'h1);
    chk("flags", {27'h0, stw[20:16]}, {27'h0, e});
    if (e[3] !== 1'b1) chk("length", {16'h0, stw[15:0]}, 32'(n + 4));
    // back onto the rising edge before the next stimulus
    @(posedge I_CLK);
  endtask : frame

  task automatic t_regs();
    rdr(8'h00);
    chk("ctrl", rd, 32'h0);
    rdr(8'h0C);
    chk("mask", rd, 32'h0);
    rdr(8'h10);
    chk("unmapped rd", {30'h0, rsp}, 32'h2);
    wr(8'h14, 32'h1);
    chk("unmapped wr", {30'h0, rsp}, 32'h2);
  endtask : t_regs
  task automatic t_good();
    int e;
    frame(12, 1'b0, 1'b0, -1, 5'h00);
    e = 0;
    foreach (fr[i]) if (got.size() <= i || got[i] !== fr[i]) e++;
    chk("fifo data", 32'(e), 32'h0);
    rdr(8'h04);
    chk("status reg", rd, 32'h00000010);
  endtask : t_good
  task automatic t_errs();
    frame(10, 1'b1, 1'b0, -1, 5'h02);
    chk("irq masked", {31'h0, irq}, 32'h0);
    frame(10, 1'b1, 1'b1, -1, 5'h03);
    frame(10, 1'b0, 1'b1, -1, 5'h00);
    frame(10, 1'b0, 1'b0, 3, 5'h02);
    // broken preamble: dropped without any status hand-over
    #10;
    phy_i.nib(4'h5, 1'b1, 1'b0);
    phy_i.nib(4'h3, 1'b1, 1'b0);
    phy_i.nib(4'hD, 1'b1, 1'b0);
    phy_i.nib(4'h0, 1'b0, 1'b0);
    repeat (20) @(posedge I_CLK);
    chk("dropped frame", {11'h0, stw}, 32'h0002000E);
  endtask : t_errs
  task automatic t_irq();
    wr(8'h0C, 32'h2);
    chk("irq on", {31'h0, irq}, 32'h1);
    rdr(8'h08);
    chk("irq stat", rd, 32'h23);
    wr(8'h08, 32'h23);
    chk("irq off", {31'h0, irq}, 32'h0);
    rdr(8'h08);
    chk("irq clr", rd, 32'h0);
    wr(8'h0C, 32'h0);
  endtask : t_irq
  task automatic t_over();
    rdy <= 1'b0;
    frame(8, 1'b0, 1'b0, -1, 5'h08);
    rdy <= 1'b1;
    repeat (10) @(posedge I_CLK);
    frame(6, 1'b0, 1'b0, -1, 5'h00);
  endtask : t_over
  task automatic t_par();
    wr(8'h00, 32'h2);
    frame(6, 1'b0, 1'b0, -1, 5'h10);
    wr(8'h00, 32'h0);
    frame(6, 1'b0, 1'b0, -1, 5'h00);
  endtask : t_par
  task automatic t_long();
    frame(1515, 1'b1, 1'b0, -1, 5'h06);
    frame(1514, 1'b1, 1'b1, -1, 5'h03);
    wr(8'h00, 32'h1);
    frame(1515, 1'b1, 1'b1, -1, 5'h03);
  endtask : t_long

  initial begin
    {I_RESET_N, rdy, awv, wv, bre, arv, rre} = 7'h00;
    {awa, ara, wd} = 48'h0;
    repeat (2) @(posedge I_CLK);
    I_RESET_N <= 1'b1;
    rdy       <= 1'b1;
    repeat (6) @(posedge I_CLK);
    t_regs();
    t_good();
    t_errs();
    t_irq();
    t_over();
    t_par();
    t_long();
    summarize();
  end
endmodule : mac_rx_err_check_tb
